// file: core/loss_of_input_monitor_and_lock.sv
`timescale 1ns/1ps
`include "lom_params.svh"
module loss_of_input_monitor_and_lock (
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic srst,
   // Monitored reference clock pin
   input wire logic reference_input_clock,
   // Sideband interface enable pin
   input wire logic sideband_enable,
   // Byte register port from the SMBus engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire lom_pkg::byte_t reg_addr,
   input wire lom_pkg::byte_t reg_wdata,
   output lom_pkg::byte_t reg_rdata,
   output logic reg_rvalid,
   // Open-drain loss indicator pin
   input wire logic loss_indicator_n_i,
   output logic loss_indicator_n_o,
   output logic loss_indicator_n_oe,
   output logic indicator_level,
   // Parked clock path
   output logic park_active,
   output logic path_out_p,
   output logic path_out_n,
   // Control bits steered by the lock
   output logic [7:1] ctrl_bits,
   output logic writes_locked
);
   import lom_pkg::*;

   logic loss_present, loss_onset, edge_seen, ref_level;

   // Presence decision feeds both the pin and the event flag
   loss_detector u_det (
      .core_clk(core_clk),
      .srst(srst),
      .ref_in(reference_input_clock),
      .loss_present(loss_present),
      .loss_onset(loss_onset),
      .edge_seen(edge_seen),
      .ref_level(ref_level)
   );

   // Register state
   logic [7:1] ctrl_r, ctrl_nxt;
   logic sticky_r, sticky_nxt;
   logic clr_lock_r, clr_lock_nxt;
   logic event_r, event_nxt;
   byte_t rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic locked;
   logic wr_ctrl, wr_sticky, wr_event;
   logic sb_s1_r, sb_s2_r, sb_on;

   // Sideband pin is asynchronous; only the synced copy is used
   assign sb_on = sb_s2_r;

   assign locked = sticky_r | clr_lock_r;
   assign wr_ctrl = reg_wr && (reg_addr == `LOM_ADDR_CTRL);
   assign wr_sticky = reg_wr && (reg_addr == `LOM_ADDR_STICKY);
   // Status byte has no meaning with the sideband disabled
   assign wr_event = reg_wr && (reg_addr == `LOM_ADDR_EVENT) &&
                     sb_on;

   always_comb begin
      ctrl_nxt = ctrl_r;
      sticky_nxt = sticky_r;
      clr_lock_nxt = clr_lock_r;
      event_nxt = event_r;
      if (wr_ctrl && !locked) begin
         ctrl_nxt = reg_wdata[7:1];
      end
      // Sticky lock has no write path back to 0
      if (wr_sticky && !locked && reg_wdata[`LOM_BIT_STICKY]) begin
         sticky_nxt = 1'b1;
      end
      // The lock byte itself stays writable, else the lock could not clear
      if (wr_event && reg_wdata[`LOM_BIT_CLR_LOCK]) begin
         clr_lock_nxt = ~clr_lock_r;
      end
      if (wr_event && reg_wdata[`LOM_BIT_EVENT]) begin
         event_nxt = 1'b0;
      end
      // Set placed last so a same-cycle loss beats the clear
      if (loss_onset) begin
         event_nxt = 1'b1;
      end
   end

   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            `LOM_ADDR_CTRL: begin
               rdata_nxt = {ctrl_r, ~loss_present};
            end
            `LOM_ADDR_STICKY: begin
               rdata_nxt = {7'h00, sticky_r};
            end
            `LOM_ADDR_EVENT: begin
               if (sb_on) begin
                  rdata_nxt = {6'h00, event_r, clr_lock_r};
               end else begin
                  rdata_nxt = 8'h00;
               end
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_r <= `LOM_CTRL_RST;
         sticky_r <= `LOM_STICKY_RST;
         clr_lock_r <= `LOM_CLR_LOCK_RST;
         event_r <= `LOM_EVENT_RST;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
         sb_s1_r <= 1'b0;
         sb_s2_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         sticky_r <= sticky_nxt;
         clr_lock_r <= clr_lock_nxt;
         event_r <= event_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         sb_s1_r <= sideband_enable;
         sb_s2_r <= sb_s1_r;
      end
   end

   // Pin side
   logic oe_r, oe_nxt;
   logic park_r, park_nxt;
   logic out_p_r, out_p_nxt;
   logic out_n_r, out_n_nxt;
   logic pin_s1_r, pin_s2_r;

   always_comb begin
      // Detector holds loss until the first edge after reset
      oe_nxt = loss_present;
      park_nxt = loss_present;
      if (loss_present) begin
         out_p_nxt = 1'b0;
         out_n_nxt = 1'b0;
      end else begin
         out_p_nxt = ref_level;
         out_n_nxt = ~ref_level;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         oe_r <= 1'b1;
         park_r <= 1'b1;
         out_p_r <= 1'b0;
         out_n_r <= 1'b0;
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         oe_r <= oe_nxt;
         park_r <= park_nxt;
         out_p_r <= out_p_nxt;
         out_n_r <= out_n_nxt;
         pin_s1_r <= loss_indicator_n_i;
         pin_s2_r <= pin_s1_r;
      end
   end

   assign loss_indicator_n_o = 1'b0;
   assign loss_indicator_n_oe = oe_r;
   assign indicator_level = pin_s2_r;
   assign park_active = park_r;
   assign path_out_p = out_p_r;
   assign path_out_n = out_n_r;
   assign ctrl_bits = ctrl_r;
   assign writes_locked = locked;
   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;

   // Checks
   a_event_set_onset: assert property (
      @(posedge core_clk) disable iff (srst)
      loss_onset |=> event_r)
      else $error("event flag not set by loss");

   a_event_no_spurious: assert property (
      @(posedge core_clk) disable iff (srst)
      (!event_r && !loss_onset) |=> !event_r)
      else $error("event flag set without loss");

   a_event_w1c: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `LOM_ADDR_EVENT && sb_on &&
       reg_wdata[1] && !loss_onset) |=> !event_r)
      else $error("event flag not cleared by write of 1");

   a_event_hold0: assert property (
      @(posedge core_clk) disable iff (srst)
      (event_r && !(reg_wr && reg_addr == `LOM_ADDR_EVENT &&
       reg_wdata[1])) |=> event_r)
      else $error("event flag lost without clearing write");

   a_event_set_wins: assert property (
      @(posedge core_clk) disable iff (srst)
      (loss_onset && wr_event && reg_wdata[1]) |=> event_r)
      else $error("clear beat same-cycle loss");

   a_ctrl_lock_hold: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `LOM_ADDR_CTRL && clr_lock_r)
      |=> $stable(ctrl_r))
      else $error("control written while locked");

   a_ctrl_open_write: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `LOM_ADDR_CTRL && !clr_lock_r && !sticky_r)
      |=> ctrl_r == $past(reg_wdata[7:1]))
      else $error("unlocked control write lost");

   a_sticky_blocks: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `LOM_ADDR_CTRL && sticky_r)
      |=> $stable(ctrl_r))
      else $error("control written under sticky lock");

   a_lock_toggle: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == `LOM_ADDR_EVENT && sb_on &&
       reg_wdata[0]) |=> clr_lock_r != $past(clr_lock_r))
      else $error("clearable lock did not toggle");

   a_sticky_never_clr: assert property (
      @(posedge core_clk) disable iff (srst)
      sticky_r |=> sticky_r [*2])
      else $error("sticky lock cleared by write");

   a_sb_read_gate: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_rd && reg_addr == `LOM_ADDR_EVENT && !sb_on)
      |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("status byte read with sideband off");

   a_live_readback: assert property (
      @(posedge core_clk) disable iff (srst)
      (reg_rd && reg_addr == `LOM_ADDR_CTRL)
      |=> reg_rdata[0] == !$past(loss_present))
      else $error("live readback wrong");

   a_ind_follow: assert property (
      @(posedge core_clk) disable iff (srst)
      ##1 loss_indicator_n_oe == $past(loss_present) &&
      !loss_indicator_n_o)
      else $error("indicator does not follow detector");

   a_first_edge: assert property (
      @(posedge core_clk) disable iff (srst)
      !edge_seen |=> loss_indicator_n_oe)
      else $error("indicator released before first edge");

   a_park_low: assert property (
      @(posedge core_clk) disable iff (srst)
      (loss_present && $past(loss_present)) |=>
      (!path_out_p && !path_out_n && park_active))
      else $error("clock path not parked low/low");

   a_onset_moves: assert property (
      @(posedge core_clk) disable iff (srst)
      loss_onset |-> loss_present ##1 loss_indicator_n_oe)
      else $error("loss onset did not pull indicator");
endmodule : loss_of_input_monitor_and_lock

// file: shared/lom_params.svh
`ifndef LOM_PARAMS_SVH
`define LOM_PARAMS_SVH

// Register byte addresses
`define LOM_ADDR_CTRL 8'h12
`define LOM_ADDR_STICKY 8'h26
`define LOM_ADDR_EVENT 8'h27

// Field positions
`define LOM_BIT_LIVE_RB 0
`define LOM_BIT_STICKY 0
`define LOM_BIT_CLR_LOCK 0
`define LOM_BIT_EVENT 1

// Reset values
`define LOM_CTRL_RST 7'h06
`define LOM_EVENT_RST 1'b0
`define LOM_STICKY_RST 1'b0
`define LOM_CLR_LOCK_RST 1'b0

// Timing: no reference edge for this long counts as loss
`define LOM_CLK_PERIOD_NS 10
`define LOM_LOSS_TIME_NS 1000
`define LOM_LOSS_CYCLES \
   ((`LOM_LOSS_TIME_NS + `LOM_CLK_PERIOD_NS - 1) / `LOM_CLK_PERIOD_NS)
`define LOM_CNT_W 8

`endif

// file: shared/lom_pkg.sv
package lom_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      DET_WAIT_FIRST,
      DET_PRESENT,
      DET_LOST
   } det_state_t;
endpackage : lom_pkg

// file: core/loss_detector.sv
`timescale 1ns/1ps
`include "lom_params.svh"
module loss_detector (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Monitored reference, asynchronous to core_clk
   input wire logic ref_in,
   // Decision
   output logic loss_present,
   output logic loss_onset,
   output logic edge_seen,
   output logic ref_level
);
   import lom_pkg::*;

   localparam logic [`LOM_CNT_W-1:0] LAST_CNT =
      `LOM_CNT_W'(`LOM_LOSS_CYCLES - 1);

   logic sync1_r, sync2_r, prev_r;
   det_state_t state_r, state_nxt;
   logic [`LOM_CNT_W-1:0] cnt_r, cnt_nxt;
   logic loss_r, loss_nxt;
   logic onset_r, onset_nxt;
   logic seen_r, seen_nxt;
   logic [1:0] warm_r, warm_nxt;
   logic edge_det;

   // Only sensible for references well below half of core_clk
   // Edges ignored until the chain holds real samples: a pin parked
   // high across reset would otherwise fake a first edge
   assign edge_det = (warm_r == 2'h3) & (sync2_r ^ prev_r);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      onset_nxt = 1'b0;
      seen_nxt = seen_r | edge_det;
      warm_nxt = (warm_r == 2'h3) ? warm_r : warm_r + 2'h1;
      case (state_r)
         DET_WAIT_FIRST: begin
            // Stays here forever if no reference ever arrives
            if (edge_det) begin
               state_nxt = DET_PRESENT;
               cnt_nxt = '0;
            end
         end
         DET_PRESENT: begin
            if (edge_det) begin
               cnt_nxt = '0;
            end else if (cnt_r == LAST_CNT) begin
               state_nxt = DET_LOST;
               onset_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + `LOM_CNT_W'(1);
            end
         end
         DET_LOST: begin
            if (edge_det) begin
               state_nxt = DET_PRESENT;
               cnt_nxt = '0;
            end
         end
         default: begin
            state_nxt = DET_WAIT_FIRST;
            cnt_nxt = '0;
         end
      endcase
      loss_nxt = (state_nxt != DET_PRESENT);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
         state_r <= DET_WAIT_FIRST;
         cnt_r <= '0;
         loss_r <= 1'b1;
         onset_r <= 1'b0;
         seen_r <= 1'b0;
         warm_r <= 2'h0;
      end else begin
         sync1_r <= ref_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         loss_r <= loss_nxt;
         onset_r <= onset_nxt;
         seen_r <= seen_nxt;
         warm_r <= warm_nxt;
      end
   end

   assign loss_present = loss_r;
   assign loss_onset = onset_r;
   assign edge_seen = seen_r;
   assign ref_level = prev_r;
endmodule : loss_detector

// file: verif/ref_source.sv
`timescale 1ns/1ps
module ref_source (
   // Source control
   input wire logic run,
   // Open-drain pin pull from the block
   input wire logic pull_oe,
   // Far-side view
   output logic ref_clk,
   output logic pin_level
);
   // 12.5 MHz, well under the aliasing limit; frozen while stopped
   initial ref_clk = 1'b0;
   always #40 begin
      if (run) ref_clk = ~ref_clk;
   end
   // External pull-up wins unless the block sinks the pin
   assign pin_level = pull_oe ? 1'b0 : 1'b1;
endmodule : ref_source

// file: verif/tb_loss_of_input_monitor_and_lock.sv
`timescale 1ns/1ps
`include "lom_params.svh"
module tb_loss_of_input_monitor_and_lock;
   import lom_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic run = 1'b0;
   logic sb_en = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   byte_t reg_addr = 8'h00;
   byte_t reg_wdata = 8'h00;
   byte_t reg_rdata;
   byte_t rv;
   logic reg_rvalid, ref_clk, pin, od_o, od_oe, ind_lvl, park, pp, pn, lk;
   logic [7:1] ctrl;
   int mismatches = 0;
   int checks_done = 0;
   always #5 core_clk = ~core_clk;
   ref_source src (.run(run), .pull_oe(od_oe), .ref_clk(ref_clk),
      .pin_level(pin));
   loss_of_input_monitor_and_lock dut (.core_clk(core_clk), .srst(srst),
      .reference_input_clock(ref_clk), .sideband_enable(sb_en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .loss_indicator_n_i(pin),
      .loss_indicator_n_o(od_o), .loss_indicator_n_oe(od_oe),
      .indicator_level(ind_lvl), .park_active(park), .path_out_p(pp),
      .path_out_n(pn), .ctrl_bits(ctrl), .writes_locked(lk));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask : step
   task automatic cmp(byte_t got, byte_t exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(byte_t a, byte_t d);
      step();
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step();
      reg_wr = 1'b0;
   endtask : wr
   task automatic rdchk(byte_t a, byte_t exp);
      step();
      reg_addr = a;
      reg_rd = 1'b1;
      step();
      reg_rd = 1'b0;
      cmp(reg_rvalid, 1'b1);
      cmp(reg_rdata, exp);
   endtask : rdchk
   // Bounded wait on the pin pull; loss time is about 100 cycles
   task automatic wait_oe(logic exp);
      int i;
      for (i = 0; i < 400 && od_oe !== exp; i++) step();
      if (od_oe !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, od_oe, exp);
         final_report();
      end
   endtask : wait_oe
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      srst = 1'b0;
      cmp(od_oe, 1'b1);
      cmp(od_o, 1'b0);
      cmp(park, 1'b1);
      cmp(ctrl, 7'h06);
      repeat (300) step();
      cmp(od_oe, 1'b1);
      rdchk(`LOM_ADDR_EVENT, 8'h00);
      rdchk(8'h40, 8'h00);
      $display("test reset done");
      run = 1'b1;
      wait_oe(1'b0);
      repeat (4) step();
      cmp(ind_lvl, 1'b1);
      cmp(park, 1'b0);
      cmp(pn, !pp);
      rdchk(`LOM_ADDR_CTRL, 8'h0D);
      rdchk(`LOM_ADDR_EVENT, 8'h00);
      $display("test start done");
      run = 1'b0;
      wait_oe(1'b1);
      repeat (4) step();
      cmp(park, 1'b1);
      cmp({pp, pn}, 8'h00);
      cmp(ind_lvl, 1'b0);
      rdchk(`LOM_ADDR_EVENT, 8'h02);
      rdchk(`LOM_ADDR_CTRL, 8'h0C);
      run = 1'b1;
      wait_oe(1'b0);
      rdchk(`LOM_ADDR_EVENT, 8'h02);
      wr(`LOM_ADDR_EVENT, 8'h00);
      rdchk(`LOM_ADDR_EVENT, 8'h02);
      wr(`LOM_ADDR_EVENT, 8'h02);
      rdchk(`LOM_ADDR_EVENT, 8'h00);
      $display("test loss done");
      run = 1'b0;
      wait_oe(1'b1);
      // Sideband pin passes two sync flops before it takes effect
      sb_en = 1'b0;
      repeat (2) step();
      rdchk(`LOM_ADDR_EVENT, 8'h00);
      wr(`LOM_ADDR_EVENT, 8'h03);
      sb_en = 1'b1;
      repeat (2) step();
      rdchk(`LOM_ADDR_EVENT, 8'h02);
      wr(`LOM_ADDR_EVENT, 8'h02);
      $display("test sideband done");
      wr(`LOM_ADDR_CTRL, 8'hA1);
      cmp(ctrl, 7'h50);
      cmp(lk, 1'b0);
      wr(`LOM_ADDR_EVENT, 8'h01);
      cmp(lk, 1'b1);
      rdchk(`LOM_ADDR_EVENT, 8'h01);
      wr(`LOM_ADDR_CTRL, 8'hFE);
      cmp(ctrl, 7'h50);
      wr(`LOM_ADDR_EVENT, 8'h01);
      cmp(lk, 1'b0);
      wr(`LOM_ADDR_CTRL, 8'h3C);
      cmp(ctrl, 7'h1E);
      wr(`LOM_ADDR_STICKY, 8'h01);
      cmp(lk, 1'b1);
      rdchk(`LOM_ADDR_STICKY, 8'h01);
      wr(`LOM_ADDR_EVENT, 8'h01);
      wr(`LOM_ADDR_EVENT, 8'h01);
      wr(`LOM_ADDR_STICKY, 8'h00);
      cmp(lk, 1'b1);
      wr(`LOM_ADDR_CTRL, 8'hFE);
      cmp(ctrl, 7'h1E);
      $display("test locks done");
      srst = 1'b1;
      repeat (16) step();
      srst = 1'b0;
      cmp(lk, 1'b0);
      cmp(ctrl, 7'h06);
      rdchk(`LOM_ADDR_STICKY, 8'h00);
      // Reference is stopped at an arbitrary level: no edge, so still pulled
      cmp(od_oe, 1'b1);
      $display("test power cycle done");
      final_report();
   end
endmodule : tb_loss_of_input_monitor_and_lock
